/* design/sb_status_defs.vh */
// Offsets, field positions, reset values and timing of the serial bus block
`ifndef SB_STATUS_DEFS_VH
`define SB_STATUS_DEFS_VH

// Register byte offsets on the plain register port
`define SB_OFF_CTRL 8'h00
`define SB_OFF_STATUS 8'h04
`define SB_OFF_TX 8'h08
`define SB_OFF_RX 8'h0C
`define SB_OFF_OWN_ADDR 8'h10
`define SB_OFF_IRQ_STAT 8'h14
`define SB_OFF_IRQ_MASK 8'h18

// Control register fields
`define SB_CTRL_ON 0
`define SB_CTRL_AUTO_STOP 1
`define SB_CTRL_GC_EN 2
`define SB_CTRL_TEN_BIT 3

// Status register fields
`define SB_ST_ACK 15
`define SB_ST_TRS 14
`define SB_ST_BCL 10
`define SB_ST_GC 9
`define SB_ST_TEN 8
`define SB_ST_WRITE_COLLISION_FLAG 7
`define SB_ST_OV 6
`define SB_ST_DA 5
`define SB_ST_STOP 4
`define SB_ST_START 3
`define SB_ST_RW 2
`define SB_ST_RBF 1
`define SB_ST_TBF 0

// Interrupt event bit positions
`define SB_EV_ACK_DONE 0
`define SB_EV_COLLISION 1
`define SB_EV_OVERFLOW 2
`define SB_EV_WR_COLL 3
`define SB_EV_STOP 4
`define SB_EV_RX_BYTE 5

// Reset values
`define SB_CTRL_RST 4'h0
`define SB_OWN_ADDR_RST 10'h000
`define SB_STATUS_RST 16'h0000

// Timing: master clock half period and system clock period
`define SB_SCL_HALF_NS 5000
`define SB_CLK_PERIOD_NS 10
`define SB_SCL_HALF_CYC \
	((`SB_SCL_HALF_NS + `SB_CLK_PERIOD_NS - 1) / `SB_CLK_PERIOD_NS)

`endif

/* design/sb_line_sync.v */
// Two-stage synchroniser and edge finder for the bus lines
`timescale 1ns/1ps
module sb_line_sync #(
	parameter W = 2
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// Raw pins and their synchronised forms
	input wire [W-1:0] i_pin,
	output wire [W-1:0] o_level,
	output wire [W-1:0] o_rise,
	output wire [W-1:0] o_fall
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : line
			reg meta_q; // First stage, read only by stage two
			reg sync_q; // Safe level
			reg prev_q; // Level one cycle older, for edges
			// Lines idle high, so reset to one avoids false edges
			always @(posedge i_sys_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
					prev_q <= 1'b1;
				end else begin
					meta_q <= i_pin[g];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end
			assign o_level[g] = sync_q;
			assign o_rise[g] = sync_q & ~prev_q;
			assign o_fall[g] = ~sync_q & prev_q;
		end
	endgenerate
endmodule

/* design/sb_irq_regs.v */
// Sticky event status, mask and level interrupt output
`timescale 1ns/1ps
module sb_irq_regs #(
	parameter N = 6
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// Events and software writes
	input wire [N-1:0] i_event,
	input wire i_wr_stat,
	input wire i_wr_mask,
	input wire [N-1:0] i_wdata,
	// State and interrupt
	output wire [N-1:0] o_status,
	output wire [N-1:0] o_mask,
	output wire o_irq
);
	reg [N-1:0] stat_q; // Sticky event bits
	reg [N-1:0] mask_q; // One enables the bit onto the interrupt
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : ev
			// Write one clears; a same-cycle event still sets
			always @(posedge i_sys_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					stat_q[g] <= 1'b0;
				end else if (i_event[g]) begin
					stat_q[g] <= 1'b1;
				end else if (i_wr_stat && i_wdata[g]) begin
					stat_q[g] <= 1'b0;
				end
			end
		end
	endgenerate
	// Mask register
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mask_q <= {N{1'b0}};
		end else if (i_wr_mask) begin
			mask_q <= i_wdata;
		end
	end
	assign o_status = stat_q;
	assign o_mask = mask_q;
	assign o_irq = |(stat_q & mask_q);
endmodule

/* design/sb_status_core.v */
// Serial bus controller with its status flag logic and register port
//
// Summary of operation
// - Ack flag updated after each slave ack slot
// - Transmit flag spans start through ack
// - Collision flag clears only by off/on cycle
// - General call flag set on match, stop clears
// - Ten-bit flag set on second byte, stop clears
// - Busy transmit write dropped, write collision flag set
// - Receive into full buffer sets overflow flag
// - Data/address flag: address clears, data sets
// - Unused status bits zero, flags reset zero
`timescale 1ns/1ps
`include "sb_status_defs.vh"
module sb_status_core #(
	parameter [15:0] HALF_CYCLES = `SB_SCL_HALF_CYC
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// Register port
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output wire [31:0] o_rdata,
	// Two-wire bus clock line
	input wire i_scl,
	output wire o_scl,
	output wire o_scl_oe,
	// Two-wire bus data line
	input wire i_sda,
	output wire o_sda,
	output wire o_sda_oe,
	// Interrupt
	output wire o_irq
);
	// Master states
	localparam [6:0] M_IDLE = 7'h01;
	localparam [6:0] M_START = 7'h02;
	localparam [6:0] M_LOW = 7'h04;
	localparam [6:0] M_HIGH = 7'h08;
	localparam [6:0] M_HOLD = 7'h10;
	localparam [6:0] M_STOPL = 7'h20;
	localparam [6:0] M_STOPH = 7'h40;
	// Slave states
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_SHIFT = 5'h02;
	localparam [4:0] S_ACKSET = 5'h04;
	localparam [4:0] S_ACKEND = 5'h08;
	localparam [4:0] S_WAIT = 5'h10;
	// Kind of the byte being received
	localparam [1:0] K_ADDR1 = 2'h0;
	localparam [1:0] K_ADDR2 = 2'h1;
	localparam [1:0] K_DATA = 2'h2;
	localparam [15:0] HALF_M1 = HALF_CYCLES - 16'h0001;
	localparam [3:0] LAST_BIT = 4'h7; // Last data bit index
	localparam [3:0] ACK_BIT = 4'h8; // Acknowledge slot index

	// Synchronised lines, bit 1 is clock and bit 0 is data
	wire [1:0] line_lvl;
	wire [1:0] line_rise;
	wire [1:0] line_fall;
	wire scl_s = line_lvl[1];
	wire sda_s = line_lvl[0];
	wire scl_rise = line_rise[1];
	wire scl_fall = line_fall[1];
	// Start and stop seen while the clock line is high
	wire start_det = scl_s & line_fall[0];
	wire stop_det = scl_s & line_rise[0];

	sb_line_sync #(
		.W(2)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_pin({i_scl, i_sda}),
		.o_level(line_lvl),
		.o_rise(line_rise),
		.o_fall(line_fall)
	);

	// Software registers
	reg [3:0] ctrl_q; // On, auto stop, general call enable, ten-bit
	reg [9:0] own_q; // Own slave address
	reg [7:0] txd_q; // Transmit holding register
	reg [7:0] rcv_q; // Receive buffer register
	reg [31:0] rdata_q; // Read data, valid one cycle after strobe
	wire on = ctrl_q[`SB_CTRL_ON];
	wire auto_stop = ctrl_q[`SB_CTRL_AUTO_STOP];
	wire gc_en = ctrl_q[`SB_CTRL_GC_EN];
	wire ten_mode = ctrl_q[`SB_CTRL_TEN_BIT];

	// Status flags
	reg ack_q; // One: no acknowledge from slave
	reg trs_q; // Master transmit in progress
	reg bcl_q; // Bus collision
	reg gc_q; // General call received
	reg ten_q; // Ten-bit address matched
	reg write_collision_flag_q; // Transmit write refused
	reg ov_q; // Receive overflow
	reg da_q; // Last byte was data
	reg p_q; // Stop seen last
	reg s_q; // Start seen last
	reg rw_q; // Direction from the address byte
	reg rbf_q; // Receive buffer full
	reg tbf_q; // Transmit buffer full

	// Master datapath
	reg [6:0] m_state_q;
	reg [15:0] hc_q; // Half period counter
	reg [3:0] bit_q; // Bit index, eight is the ack slot
	reg [7:0] msh_q; // Outgoing byte, msb first
	wire tick = (hc_q == HALF_M1);

	// Slave datapath
	reg [4:0] s_state_q;
	reg [7:0] ssh_q; // Incoming shift register
	reg [2:0] scnt_q; // Bits received in this byte
	reg [1:0] kind_q;
	reg ack_pend_q; // Acknowledge to give in the coming slot
	reg ack_drv_q; // Slave pulls the data line low
	reg read_q; // Addressed for read, data not served

	// Register port decode
	wire wr_ctrl = i_wr & (i_addr == `SB_OFF_CTRL);
	wire wr_stat = i_wr & (i_addr == `SB_OFF_STATUS);
	wire wr_tx = i_wr & (i_addr == `SB_OFF_TX);
	wire wr_own = i_wr & (i_addr == `SB_OFF_OWN_ADDR);
	wire wr_ist = i_wr & (i_addr == `SB_OFF_IRQ_STAT);
	wire wr_imask = i_wr & (i_addr == `SB_OFF_IRQ_MASK);
	wire rd_rx = i_rd & (i_addr == `SB_OFF_RX);

	// Busy covers a queued byte and every phase but idle and hold
	wire m_busy = tbf_q | ~((m_state_q == M_IDLE) | (m_state_q == M_HOLD));
	wire tx_accept = wr_tx & on & ~m_busy;
	wire tx_reject = wr_tx & on & m_busy;

	// Collision: we released data for a one but the line is low
	wire coll = (m_state_q == M_HIGH) & tick & (bit_q < ACK_BIT) &
		msh_q[7] & ~sda_s;
	wire ack_done = (m_state_q == M_HIGH) & tick & (bit_q == ACK_BIT);

	// Slave byte evaluation, using the bit arriving on this edge
	wire [7:0] byte_now = {ssh_q[6:0], sda_s};
	wire byte_done = (s_state_q == S_SHIFT) & scl_rise & (scnt_q == 3'h7);
	wire gc_hit = (kind_q == K_ADDR1) & gc_en & (byte_now == 8'h00);
	wire ten_hi = (kind_q == K_ADDR1) & ten_mode &
		(byte_now[7:3] == 5'b11110) & (byte_now[2:1] == own_q[9:8]) &
		~byte_now[0];
	wire seven_hit = (kind_q == K_ADDR1) & ~ten_mode & ~gc_hit &
		(byte_now[7:1] == own_q[6:0]);
	wire ten_lo = (kind_q == K_ADDR2) & (byte_now == own_q[7:0]);
	wire data_byte = (kind_q == K_DATA);
	wire addr_match = gc_hit | seven_hit | ten_lo;
	wire ack_now = addr_match | ten_hi | (data_byte & ~rbf_q);
	wire ov_event = byte_done & data_byte & rbf_q;
	wire rx_store = byte_done & data_byte & ~rbf_q;

	// Control and address registers
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q <= `SB_CTRL_RST;
			own_q <= `SB_OWN_ADDR_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= i_wdata[3:0];
			end
			if (wr_own) begin
				own_q <= i_wdata[9:0];
			end
		end
	end

	// Half period counter, stopped while the master waits
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hc_q <= 16'h0000;
		end else if ((m_state_q == M_IDLE) || (m_state_q == M_HOLD) ||
			tick) begin
			hc_q <= 16'h0000;
		end else begin
			hc_q <= hc_q + 16'h0001;
		end
	end

	// Master transmit sequencer
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			m_state_q <= M_IDLE;
			bit_q <= 4'h0;
			msh_q <= 8'h00;
		end else if (!on) begin
			// Turning the module off abandons any transfer
			m_state_q <= M_IDLE;
		end else begin
			case (m_state_q)
				M_IDLE: begin
					if (tx_accept) begin
						m_state_q <= M_START;
						bit_q <= 4'h0;
						msh_q <= i_wdata[7:0];
					end
				end
				M_START: begin
					if (tick) begin
						m_state_q <= M_LOW;
					end
				end
				M_LOW: begin
					if (tick) begin
						m_state_q <= M_HIGH;
					end
				end
				M_HIGH: begin
					if (coll) begin
						// Lose arbitration: release both lines at once
						m_state_q <= M_IDLE;
					end else if (tick && bit_q == ACK_BIT) begin
						m_state_q <= auto_stop ? M_STOPL : M_HOLD;
					end else if (tick) begin
						bit_q <= bit_q + 4'h1;
						msh_q <= {msh_q[6:0], 1'b0};
						m_state_q <= M_LOW;
					end
				end
				M_HOLD: begin
					// Clock held low until software gives the next byte
					if (tx_accept) begin
						m_state_q <= M_LOW;
						bit_q <= 4'h0;
						msh_q <= i_wdata[7:0];
					end
				end
				M_STOPL: begin
					if (tick) begin
						m_state_q <= M_STOPH;
					end
				end
				M_STOPH: begin
					// Data released on return to idle makes the stop
					if (tick) begin
						m_state_q <= M_IDLE;
					end
				end
				default: begin
					m_state_q <= M_IDLE;
				end
			endcase
		end
	end

	// Slave receiver, stepped by sampled clock edges
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_state_q <= S_IDLE;
			ssh_q <= 8'h00;
			scnt_q <= 3'h0;
			kind_q <= K_ADDR1;
			ack_pend_q <= 1'b0;
			ack_drv_q <= 1'b0;
			read_q <= 1'b0;
		end else if (!on || stop_det) begin
			s_state_q <= S_IDLE;
			ack_drv_q <= 1'b0;
		end else if (start_det) begin
			// Our own master transfer is not answered by our slave
			s_state_q <= (m_state_q == M_IDLE) ? S_SHIFT : S_WAIT;
			scnt_q <= 3'h0;
			kind_q <= K_ADDR1;
			ack_drv_q <= 1'b0;
			read_q <= 1'b0;
		end else begin
			case (s_state_q)
				S_IDLE: begin
					ack_drv_q <= 1'b0;
				end
				S_SHIFT: begin
					if (scl_rise) begin
						ssh_q <= byte_now;
						scnt_q <= scnt_q + 3'h1;
					end
					if (byte_done) begin
						s_state_q <= S_ACKSET;
						ack_pend_q <= ack_now;
						read_q <= seven_hit & byte_now[0];
						if (ten_hi) begin
							kind_q <= K_ADDR2;
						end else if (addr_match) begin
							kind_q <= K_DATA;
						end
					end
				end
				S_ACKSET: begin
					if (scl_fall) begin
						ack_drv_q <= ack_pend_q;
						s_state_q <= S_ACKEND;
					end
				end
				S_ACKEND: begin
					// Reads are acknowledged but not served
					if (scl_fall) begin
						ack_drv_q <= 1'b0;
						scnt_q <= 3'h0;
						s_state_q <= (ack_pend_q && !read_q) ?
							S_SHIFT : S_WAIT;
					end
				end
				S_WAIT: begin
					ack_drv_q <= 1'b0;
				end
				default: begin
					s_state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Status flags; software, read and off clears come first so a same-cycle set wins
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{ack_q, trs_q, bcl_q, gc_q, ten_q, write_collision_flag_q, ov_q} <= 7'h00;
			{da_q, p_q, s_q, rw_q, rbf_q, tbf_q} <= 6'h00;
			txd_q <= 8'h00;
			rcv_q <= 8'h00;
		end else begin
			if (wr_stat && i_wdata[`SB_ST_WRITE_COLLISION_FLAG]) begin
				write_collision_flag_q <= 1'b0;
			end
			if (wr_stat && i_wdata[`SB_ST_OV]) begin
				ov_q <= 1'b0;
			end
			if (wr_stat && i_wdata[`SB_ST_STOP]) begin
				p_q <= 1'b0;
			end
			if (wr_stat && i_wdata[`SB_ST_START]) begin
				s_q <= 1'b0;
			end
			if (rd_rx) begin
				rbf_q <= 1'b0;
			end
			if (!on) begin
				bcl_q <= 1'b0;
				trs_q <= 1'b0;
				tbf_q <= 1'b0;
			end
			// Master side
			if (tx_accept) begin
				txd_q <= i_wdata[7:0];
				trs_q <= 1'b1;
				tbf_q <= 1'b1;
			end
			if (tx_reject) begin
				write_collision_flag_q <= 1'b1;
			end
			if ((m_state_q == M_HIGH) && tick && bit_q == LAST_BIT) begin
				tbf_q <= 1'b0;
			end
			if (ack_done) begin
				ack_q <= sda_s;
				trs_q <= 1'b0;
			end
			if (coll) begin
				bcl_q <= 1'b1;
				trs_q <= 1'b0;
				tbf_q <= 1'b0;
			end
			// Slave side
			if (byte_done && addr_match) begin
				da_q <= 1'b0;
				rw_q <= seven_hit & byte_now[0];
			end
			if (byte_done && data_byte) begin
				da_q <= 1'b1;
			end
			if (byte_done && gc_hit) begin
				gc_q <= 1'b1;
			end
			if (byte_done && ten_lo) begin
				ten_q <= 1'b1;
			end
			if (ov_event) begin
				ov_q <= 1'b1;
			end
			if (rx_store) begin
				rcv_q <= byte_now;
				rbf_q <= 1'b1;
			end
			// Bus conditions
			if (start_det) begin
				s_q <= 1'b1;
				p_q <= 1'b0;
			end
			if (stop_det) begin
				p_q <= 1'b1;
				s_q <= 1'b0;
				gc_q <= 1'b0;
				ten_q <= 1'b0;
			end
		end
	end

	// Event status, mask and interrupt line
	wire [5:0] irq_stat;
	wire [5:0] irq_mask;
	wire [5:0] events;
	assign events[`SB_EV_ACK_DONE] = ack_done;
	assign events[`SB_EV_COLLISION] = coll;
	assign events[`SB_EV_OVERFLOW] = ov_event;
	assign events[`SB_EV_WR_COLL] = tx_reject;
	assign events[`SB_EV_STOP] = stop_det;
	assign events[`SB_EV_RX_BYTE] = rx_store;

	sb_irq_regs #(
		.N(6)
	) u_irq (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_event(events),
		.i_wr_stat(wr_ist),
		.i_wr_mask(wr_imask),
		.i_wdata(i_wdata[5:0]),
		.o_status(irq_stat),
		.o_mask(irq_mask),
		.o_irq(o_irq)
	);

	// Status word, unimplemented bits forced to zero
	wire [31:0] status_word = {16'h0000, ack_q, trs_q, 3'b000, bcl_q,
		gc_q, ten_q, write_collision_flag_q, ov_q, da_q, p_q, s_q, rw_q, rbf_q,
		tbf_q};

	// Read data register, zero outside the answer cycle
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (!i_rd) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			case (i_addr)
				`SB_OFF_CTRL: rdata_q <= {28'h000_0000, ctrl_q};
				`SB_OFF_STATUS: rdata_q <= status_word;
				`SB_OFF_TX: rdata_q <= {24'h00_0000, txd_q};
				`SB_OFF_RX: rdata_q <= {24'h00_0000, rcv_q};
				`SB_OFF_OWN_ADDR: rdata_q <= {22'h00_0000, own_q};
				`SB_OFF_IRQ_STAT: rdata_q <= {26'h000_0000, irq_stat};
				`SB_OFF_IRQ_MASK: rdata_q <= {26'h000_0000, irq_mask};
				// Unmapped addresses answer zero
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign o_rdata = rdata_q;

	// Open-drain pins: always drive low, enable decides
	assign o_scl = 1'b0;
	assign o_sda = 1'b0;
	assign o_scl_oe = (m_state_q == M_LOW) | (m_state_q == M_HOLD) |
		(m_state_q == M_STOPL);
	assign o_sda_oe = ack_drv_q | (m_state_q == M_START) |
		(m_state_q == M_STOPL) | (m_state_q == M_STOPH) |
		(((m_state_q == M_LOW) | (m_state_q == M_HIGH)) &
		(bit_q < ACK_BIT) & ~msh_q[7]);
endmodule

/* test/sb_status_core_props.sv */
// Port-level assertions for the serial bus status block
`timescale 1ns/1ps
`include "sb_status_defs.vh"
module sb_status_core_props #(
	parameter [15:0] HALF_CYCLES = 16'h0008
) (
	// Clock, reset and register port
	input wire i_sys_clk,
	input wire i_reset_n,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	// Bus lines and interrupt
	input wire i_scl,
	input wire o_scl,
	input wire o_scl_oe,
	input wire i_sda,
	input wire o_sda,
	input wire o_sda_oe,
	input wire o_irq
);
	// Phase checks assume the bench value of eight clocks per half
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	chk_rdata_one_cycle: assert property (
		!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	chk_status_pad_zero: assert property (
		$past(i_rd) && $past(i_addr) == `SB_OFF_STATUS
		|-> o_rdata[31:16] == 16'h0000 && o_rdata[13:11] == 3'h0)
		else $error("unused status bits not zero");
	chk_reset_quiet: assert property (
		$rose(i_reset_n) |-> !o_scl_oe && !o_sda_oe && !o_irq)
		else $error("outputs active after reset");
	chk_off_releases: assert property (
		i_wr && i_addr == `SB_OFF_CTRL && !i_wdata[0]
		|=> ##1 (!o_scl_oe && !o_sda_oe)[*3])
		else $error("lines driven while disabled");
	chk_scl_low_len: assert property (
		$rose(o_scl_oe) |-> o_scl_oe[*8])
		else $error("clock low phase too short");
	chk_scl_high_len: assert property (
		$fell(o_scl_oe) |-> !o_scl_oe[*8])
		else $error("clock high phase too short");
	chk_pins_low: assert property (
		!o_scl && !o_sda)
		else $error("open-drain pin driven high");
	chk_mask_quiet: assert property (
		i_wr && i_addr == `SB_OFF_IRQ_MASK && i_wdata[5:0] == 6'h00
		|=> !o_irq)
		else $error("interrupt while all masked");
	chk_unmapped_zero: assert property (
		$past(i_rd) && $past(i_addr) > `SB_OFF_IRQ_MASK
		|-> o_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	// Main scenarios reached
	cover property ($rose(o_irq));
	cover property ($rose(o_sda_oe) && !o_scl_oe);
	cover property ($past(i_rd) && o_rdata[10]);
endmodule
bind sb_status_core sb_status_core_props #(.HALF_CYCLES(HALF_CYCLES)) props_u (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(i_sda),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_irq(o_irq)
);

/* test/sb_far_device.sv */
// Far-side bus device: acking slave and simple master
`timescale 1ns/1ps
module sb_far_device (
	// Wire levels
	input wire i_scl,
	input wire i_sda,
	// Scenario controls
	input wire i_ack_en,
	input wire i_hold_sda,
	// Pulls, high drives the line low
	output reg o_scl_oe,
	output wire o_sda_oe,
	// Last byte seen as slave
	output reg [7:0] o_byte
);
	reg m_busy; // Own master cycle running
	reg m_sda; // Master pull on data
	reg s_ack; // Slave ack pull
	reg [3:0] bit_n; // Clock rises in the current byte
	reg [7:0] sh; // Bits gathered in the current byte
	reg [7:0] starts; // Starts seen on the wires
	reg [7:0] starts_seen; // Starts already taken by the counter
	// Rise index; a fresh start restarts the byte at zero
	wire [3:0] n = (starts !== starts_seen) ? 4'h0 : bit_n;
	// Everything released at start
	initial begin
		o_scl_oe = 1'b0;
		m_busy = 1'b0;
		m_sda = 1'b0;
		s_ack = 1'b0;
		bit_n = 4'h0;
		o_byte = 8'h00;
		sh = 8'h00;
		starts = 8'h00;
		starts_seen = 8'h00;
	end
	// Open drain: released lines float up to the pull-up level
	assign o_sda_oe = m_sda | s_ack | i_hold_sda;
	// Count rises from the last start; stop-phase rises never reach o_byte
	always @(posedge i_scl) begin
		if (!m_busy) begin
			starts_seen <= starts;
			if (n < 4'h8) begin
				sh <= {sh[6:0], i_sda};
			end
			if (n == 4'h7) begin
				o_byte <= {sh[6:0], i_sda};
			end
			bit_n <= (n == 4'h8) ? 4'h0 : n + 4'h1;
		end
	end
	// A start is data falling while the clock is high
	always @(negedge i_sda) begin
		if (i_scl === 1'b1) begin
			starts <= starts + 8'h01;
		end
	end
	// Ack held from the fall after bit eight to the next fall
	always @(negedge i_scl) begin
		if (!m_busy) begin
			s_ack <= i_ack_en && (bit_n == 4'h8);
		end
	end
	// Start: data falls with the clock high
	task m_start;
		begin
			m_busy = 1'b1;
			m_sda = 1'b1;
			#80;
			o_scl_oe = 1'b1;
		end
	endtask
	// One bit of a 160 ns link clock; data moves only while low
	task m_bit(input b, output s);
		begin
			#40;
			m_sda = !b;
			#40;
			o_scl_oe = 1'b0;
			#40;
			s = i_sda;
			#40;
			o_scl_oe = 1'b1;
		end
	endtask
	// Byte then ack slot; may refill a full receiver on purpose
	task m_byte(input [7:0] v, output nack);
		integer k;
		reg s;
		begin
			for (k = 7; k >= 0; k = k - 1) begin
				m_bit(v[k], s);
			end
			m_bit(1'b1, nack);
		end
	endtask
	// Stop: data rises while the clock is high
	task m_stop;
		begin
			#40;
			m_sda = 1'b1;
			#40;
			o_scl_oe = 1'b0;
			#80;
			m_sda = 1'b0;
			#80;
			m_busy = 1'b0;
		end
	endtask
endmodule

/* test/tb_i2c_status_flag_logic.sv */
// Self-checking bench for the serial bus status block
`timescale 1ns/1ps
`include "sb_status_defs.vh"
module tb_i2c_status_flag_logic;
	// Clock, reset and register port
	reg i_sys_clk;
	reg i_reset_n;
	reg [7:0] i_addr;
	reg [31:0] i_wdata;
	reg i_wr;
	reg i_rd;
	wire [31:0] o_rdata;
	// Bus pulls, wire levels and interrupt
	wire o_scl;
	wire o_sda;
	wire o_scl_oe;
	wire o_sda_oe;
	wire far_scl_oe;
	wire far_sda_oe;
	wire scl_w;
	wire sda_w;
	wire o_irq;
	wire [7:0] far_byte;
	reg ack_en;
	reg hold_sda;
	integer err_total;
	integer total_checks;
	reg [31:0] rdat;
	reg nk;
	// Pull-ups: a line is high unless someone drives it
	assign scl_w = !(o_scl_oe | far_scl_oe);
	assign sda_w = !(o_sda_oe | far_sda_oe);
	sb_status_core #(.HALF_CYCLES(16'h0008)) dut_u (
		.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_scl(scl_w), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
		.i_sda(sda_w), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_irq(o_irq)
	);
	sb_far_device far_u (
		.i_scl(scl_w), .i_sda(sda_w), .i_ack_en(ack_en),
		.i_hold_sda(hold_sda), .o_scl_oe(far_scl_oe),
		.o_sda_oe(far_sda_oe), .o_byte(far_byte)
	);
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks=%0d errors=%0d", total_checks, err_total);
			if (err_total == 0 && total_checks > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask
	// Register writes and reads, one strobe cycle each
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge i_sys_clk);
			i_addr <= a;
			i_wdata <= d;
			i_wr <= 1'b1;
			@(posedge i_sys_clk);
			i_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, output [31:0] d);
		begin
			@(posedge i_sys_clk);
			i_addr <= a;
			i_rd <= 1'b1;
			@(posedge i_sys_clk);
			i_rd <= 1'b0;
			@(negedge i_sys_clk);
			d = o_rdata;
		end
	endtask
	task st(input [31:0] m, input [31:0] e);
		begin
			rd(`SB_OFF_STATUS, rdat);
			chk(rdat & m, e);
		end
	endtask
	// Bounded wait on status bits; a timeout ends the run
	task poll(input [31:0] m, input [31:0] e);
		integer k;
		begin
			k = 0;
			rd(`SB_OFF_STATUS, rdat);
			while ((rdat & m) !== e && k < 400) begin
				rd(`SB_OFF_STATUS, rdat);
				k = k + 1;
			end
			if ((rdat & m) !== e) begin
				chk(rdat & m, e);
				report_and_stop;
			end
		end
	endtask
	// Transfer over and both lines released after the stop
	task idle_wait;
		integer k;
		begin
			poll(32'h0000_4001, 32'h0000_0000);
			k = 0;
			while ((o_scl_oe | o_sda_oe) !== 1'b0 && k < 100) begin
				@(negedge i_sys_clk);
				k = k + 1;
			end
			chk({30'h0000_0000, o_scl_oe, o_sda_oe}, 32'h0000_0000);
			if ((o_scl_oe | o_sda_oe) !== 1'b0) begin
				report_and_stop;
			end
		end
	endtask
	task irq_is(input b);
		begin
			@(negedge i_sys_clk);
			chk({31'h0000_0000, o_irq}, {31'h0000_0000, b});
		end
	endtask
	task t_reset;
		begin
			st(32'hFFFF_FFFF, 32'h0000_0000);
			wr(`SB_OFF_STATUS, 32'hFFFF_FFFF);
			st(32'hFFFF_FFFF, 32'h0000_0000);
			rd(8'h1C, rdat);
			chk(rdat, 32'h0000_0000);
			$display("t_reset end");
		end
	endtask
	// Nack then ack as master; busy write dropped; interrupt paths
	task t_master;
		begin
			ack_en = 1'b0;
			wr(`SB_OFF_CTRL, 32'h0000_0003);
			wr(`SB_OFF_TX, 32'h0000_00C3);
			idle_wait;
			st(32'h0000_C000, 32'h0000_8000);
			wr(`SB_OFF_IRQ_MASK, 32'h0000_0001);
			irq_is(1'b1);
			wr(`SB_OFF_IRQ_MASK, 32'h0000_0000);
			irq_is(1'b0);
			wr(`SB_OFF_IRQ_MASK, 32'h0000_0001);
			wr(`SB_OFF_IRQ_STAT, 32'h0000_003F);
			irq_is(1'b0);
			ack_en = 1'b1;
			wr(`SB_OFF_TX, 32'h0000_00A5);
			wr(`SB_OFF_TX, 32'h0000_005A);
			st(32'h0000_4081, 32'h0000_4081);
			idle_wait;
			chk({24'h00_0000, far_byte}, 32'h0000_00A5);
			st(32'h0000_C081, 32'h0000_0080);
			wr(`SB_OFF_STATUS, 32'h0000_0080);
			st(32'h0000_0080, 32'h0000_0000);
			$display("t_master end");
		end
	endtask
	// Slave: address, data, overflow, stop, general call
	task t_slave;
		begin
			wr(`SB_OFF_OWN_ADDR, 32'h0000_002A);
			wr(`SB_OFF_CTRL, 32'h0000_0005);
			far_u.m_start;
			far_u.m_byte(8'h54, nk);
			chk({31'h0000_0000, nk}, 32'h0000_0000);
			st(32'h0000_0020, 32'h0000_0000);
			far_u.m_byte(8'h3C, nk);
			st(32'h0000_0022, 32'h0000_0022);
			rd(`SB_OFF_RX, rdat);
			chk(rdat, 32'h0000_003C);
			far_u.m_byte(8'h11, nk);
			far_u.m_byte(8'h22, nk);
			chk({31'h0000_0000, nk}, 32'h0000_0001);
			st(32'h0000_0042, 32'h0000_0042);
			rd(`SB_OFF_RX, rdat);
			chk(rdat, 32'h0000_0011);
			far_u.m_stop;
			st(32'h0000_0018, 32'h0000_0010);
			wr(`SB_OFF_STATUS, 32'h0000_0040);
			st(32'h0000_0040, 32'h0000_0000);
			far_u.m_start;
			far_u.m_byte(8'h00, nk);
			st(32'h0000_0218, 32'h0000_0208);
			far_u.m_stop;
			st(32'h0000_0200, 32'h0000_0000);
			far_u.m_start;
			far_u.m_byte(8'h55, nk);
			st(32'h0000_0024, 32'h0000_0004);
			far_u.m_stop;
			$display("t_slave end");
		end
	endtask
	task t_ten;
		begin
			wr(`SB_OFF_OWN_ADDR, 32'h0000_02A5);
			wr(`SB_OFF_CTRL, 32'h0000_0009);
			far_u.m_start;
			far_u.m_byte(8'hF4, nk);
			st(32'h0000_0100, 32'h0000_0000);
			far_u.m_byte(8'hA5, nk);
			st(32'h0000_0120, 32'h0000_0100);
			far_u.m_stop;
			st(32'h0000_0100, 32'h0000_0000);
			$display("t_ten end");
		end
	endtask
	// Data held low under a released one; only off/on clears it
	task t_coll;
		integer k;
		begin
			wr(`SB_OFF_CTRL, 32'h0000_0003);
			wr(`SB_OFF_TX, 32'h0000_00FF);
			k = 0;
			while (o_scl_oe !== 1'b1 && k < 100) begin
				@(negedge i_sys_clk);
				k = k + 1;
			end
			if (o_scl_oe !== 1'b1) begin
				chk({31'h0000_0000, o_scl_oe}, 32'h0000_0001);
				report_and_stop;
			end
			hold_sda = 1'b1;
			poll(32'h0000_0400, 32'h0000_0400);
			wr(`SB_OFF_STATUS, 32'h0000_FFFF);
			hold_sda <= 1'b0;
			wr(`SB_OFF_CTRL, 32'h0000_0003);
			st(32'h0000_0400, 32'h0000_0400);
			wr(`SB_OFF_CTRL, 32'h0000_0000);
			wr(`SB_OFF_CTRL, 32'h0000_0003);
			st(32'h0000_0400, 32'h0000_0000);
			$display("t_coll end");
		end
	endtask
	initial begin
		i_reset_n = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0000_0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		ack_en = 1'b1;
		hold_sda = 1'b0;
		err_total = 0;
		total_checks = 0;
		repeat (8) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		t_reset;
		t_master;
		t_slave;
		t_ten;
		t_coll;
		report_and_stop;
	end
endmodule
